// ---- swo_host.sv ----
// One-wire OTP programming host: reset, slots, CRC check, program pulse
// Summary of operation
// - Memory write: skip id, code 0Fh, address low, high, one data byte.
// - On CRC match, host applies programming voltage for the program time.
// - On a bad CRC, host issues reset and restarts the whole sequence, up to MAX_RETRY times, then ends with ERR_CRC.
// - Abort ends a write anywhere except during the program pulse and its recovery.
// - Status write: skip id, code 55h, address low, high, then data bytes up to the last one.
// - After the pulse and line recovery, host reads eight verify slots.
// - Address and data bytes go least significant bit first.
// - Host opens every slot with a low strobe; device answers reads.
// - Write slot: host holds low for zero; read slot: device does.
// - High line is idle; transfers may pause there indefinitely.
module swo_host #(
    parameter int RESET_CYC    = swo_pkg::C_RESET,
    parameter int PRES_END_CYC = swo_pkg::C_PRES_END,
    parameter int SLOT_CYC     = swo_pkg::C_SLOT,
    parameter int PROG_CYC     = swo_pkg::C_PROG,
    parameter int TMR_W        = 17,
    parameter int MAX_RETRY    = 3,
    parameter int FIFO_DEPTH   = 4
) (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        ce_i,
    // Command
    input  wire logic        start_i,
    input  wire logic        mode_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        abort_i,
    // Write data stream
    input  wire logic        wr_valid_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        wr_last_i,
    output logic             wr_ready_o,
    // Status
    output logic             busy_o,
    output logic             done_o,
    output logic [2:0]       err_o,
    output logic [15:0]      addr_o,
    output logic [7:0]       verify_o,
    output logic [15:0]      crc_o,
    // Line
    input  wire logic        dq_i,
    output logic             dq_o,
    output logic             dq_oe_n_o,
    output logic             prog_en_o
);
    localparam int RTY_W = $clog2(MAX_RETRY + 1);
    localparam int FW    = swo_pkg::BYTE_W + 1;

    generate
        if ($clog2(RESET_CYC + 1) > TMR_W || $clog2(PROG_CYC + 1) > TMR_W
            || $clog2(PRES_END_CYC + 1) > TMR_W
            || SLOT_CYC <= swo_pkg::C_SAMPLE + swo_pkg::C_RECOVER
            || PRES_END_CYC <= swo_pkg::C_PRES_SMP + 1
            || MAX_RETRY < 1) begin : g_bad_param
            $error("swo_host: timing parameters out of range");
        end
    endgenerate

    localparam logic [TMR_W-1:0] L_RESET  = TMR_W'(RESET_CYC - 1);
    localparam logic [TMR_W-1:0] L_PSMP   = TMR_W'(swo_pkg::C_PRES_SMP);
    localparam logic [TMR_W-1:0] L_PEND   = TMR_W'(PRES_END_CYC - 1);
    localparam logic [TMR_W-1:0] L_STROBE = TMR_W'(swo_pkg::C_STROBE);
    localparam logic [TMR_W-1:0] L_SAMPLE = TMR_W'(swo_pkg::C_SAMPLE);
    localparam logic [TMR_W-1:0] L_LOW0   =
        TMR_W'(SLOT_CYC - swo_pkg::C_RECOVER);
    localparam logic [TMR_W-1:0] L_SLOT   = TMR_W'(SLOT_CYC - 1);
    localparam logic [TMR_W-1:0] L_PROG   = TMR_W'(PROG_CYC - 1);
    localparam logic [TMR_W-1:0] L_PREC   = TMR_W'(swo_pkg::C_PROG_REC - 1);
    localparam logic [RTY_W-1:0] L_RETRY  = RTY_W'(MAX_RETRY);

    swo_pkg::swo_state_e state, next_state;
    swo_pkg::swo_step_e  step, next_step;
    logic [TMR_W-1:0] tmr, next_tmr;
    logic [3:0]       bitn, next_bitn;
    logic [7:0]       shreg, next_shreg;
    logic [15:0]      rx, next_rx;
    logic [15:0]      crc, next_crc;
    logic [15:0]      addr, next_addr;
    logic [7:0]       dbyte, next_dbyte;
    logic             last, next_last;
    logic             hv, next_hv;
    logic             mode, next_mode;
    logic             quit, next_quit;
    logic             samp, next_samp;
    logic [RTY_W-1:0] retry, next_retry;
    logic [2:0]       err, next_err;
    logic             done, next_done;
    logic             drv, next_drv;
    logic             prog, next_prog;
    logic [7:0]       vbyte, next_vbyte;
    logic [15:0]      crcin, next_crcin;
    logic             pop;
    logic             rxmode;
    logic [15:0]      rx_full;
    logic             f_valid;
    logic [FW-1:0]    f_data;

    // Bit-serial CRC16, LSB first
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic        b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = (c >> 1) ^ (fb ? swo_pkg::CRC16_POLY : 16'h0000);
    endfunction : crc_step

    swo_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .ce_i        (ce_i),
        .in_valid_i  (wr_valid_i),
        .in_data_i   ({wr_last_i, wr_data_i}),
        .in_ready_o  (wr_ready_o),
        .out_valid_o (f_valid),
        .out_data_o  (f_data),
        .out_ready_i (pop)
    );

    assign rx_full = {samp, rx[15:1]};

    always_comb begin
        next_state = state;
        next_step  = step;
        next_tmr   = tmr + 1'b1;
        next_bitn  = bitn;
        next_shreg = shreg;
        next_rx    = rx;
        next_crc   = crc;
        next_addr  = addr;
        next_dbyte = dbyte;
        next_last  = last;
        next_hv    = hv;
        next_mode  = mode;
        next_quit  = quit;
        next_samp  = samp;
        next_retry = retry;
        next_err   = err;
        next_done  = 1'b0;
        next_vbyte = vbyte;
        next_crcin = crcin;
        pop        = 1'b0;
        unique case (state)
            swo_pkg::SWO_IDLE: begin
                next_tmr = '0;
                if (start_i) begin
                    next_mode  = mode_i;
                    next_addr  = addr_i;
                    next_retry = '0;
                    next_hv    = 1'b0;
                    next_err   = swo_pkg::ERR_NONE;
                    next_quit  = 1'b0;
                    next_state = swo_pkg::SWO_RESET;
                end
            end
            swo_pkg::SWO_RESET: begin
                if (tmr == L_RESET) begin
                    next_tmr   = '0;
                    next_state = swo_pkg::SWO_PRES;
                end
            end
            swo_pkg::SWO_PRES: begin
                if (tmr == L_PSMP && dq_i && !quit) begin
                    next_err  = swo_pkg::ERR_PRESENCE;
                    next_quit = 1'b1;
                end
                if (tmr == L_PEND) begin
                    next_tmr = '0;
                    if (quit) begin
                        next_state = swo_pkg::SWO_END;
                    end else begin
                        next_step  = swo_pkg::SWO_P_ROM;
                        next_shreg = swo_pkg::CMD_SKIP_ID;
                        next_bitn  = '0;
                        next_state = swo_pkg::SWO_SLOT;
                    end
                end
            end
            swo_pkg::SWO_SLOT: begin
                if (tmr == L_SAMPLE) begin
                    next_samp = dq_i;
                end
                if (tmr == L_SLOT) begin
                    next_tmr  = '0;
                    next_bitn = bitn + 1'b1;
                    if (step == swo_pkg::SWO_P_CRC
                        || step == swo_pkg::SWO_P_VERIFY) begin
                        next_rx = rx_full;
                    end else begin
                        next_shreg = shreg >> 1;
                        if (step != swo_pkg::SWO_P_ROM) begin
                            next_crc = crc_step(crc, shreg[0]);
                        end
                    end
                    if (bitn == ((step == swo_pkg::SWO_P_CRC) ? 4'hf : 4'h7))
                    begin
                        next_bitn = '0;
                        unique case (step)
                            swo_pkg::SWO_P_ROM: begin
                                next_crc   = swo_pkg::CRC16_INIT;
                                next_step  = swo_pkg::SWO_P_CMD;
                                next_shreg = mode ? swo_pkg::CMD_WRITE_STAT
                                                  : swo_pkg::CMD_WRITE_MEM;
                            end
                            swo_pkg::SWO_P_CMD: begin
                                next_step  = swo_pkg::SWO_P_ALO;
                                next_shreg = addr[7:0];
                            end
                            swo_pkg::SWO_P_ALO: begin
                                next_step  = swo_pkg::SWO_P_AHI;
                                next_shreg = addr[15:8];
                            end
                            swo_pkg::SWO_P_AHI: begin
                                next_step  = swo_pkg::SWO_P_DATA;
                                next_shreg = dbyte;
                                if (!hv) begin
                                    next_state = swo_pkg::SWO_WAITD;
                                end
                            end
                            swo_pkg::SWO_P_DATA: begin
                                next_step = swo_pkg::SWO_P_CRC;
                            end
                            swo_pkg::SWO_P_CRC: begin
                                next_crcin = rx_full;
                                // Device echoes; the host alone decides
                                if ((rx_full ^ swo_pkg::CRC16_XOR) == crc)
                                begin
                                    next_tmr   = '0;
                                    next_state = swo_pkg::SWO_PROG;
                                end else if (retry == L_RETRY) begin
                                    next_err   = swo_pkg::ERR_CRC;
                                    next_quit  = 1'b1;
                                    next_state = swo_pkg::SWO_RESET;
                                end else begin
                                    next_retry = retry + 1'b1;
                                    next_state = swo_pkg::SWO_RESET;
                                end
                            end
                            default: begin
                                next_vbyte = rx_full[15:8];
                                next_hv    = 1'b0;
                                // Blank bits read one, so good byte == data
                                if (rx_full[15:8] != dbyte) begin
                                    next_err   = swo_pkg::ERR_VERIFY;
                                    next_quit  = 1'b1;
                                    next_state = swo_pkg::SWO_RESET;
                                end else if (mode && !last) begin
                                    // Mirror the device's own increment
                                    next_addr  = addr + 16'h0001;
                                    next_crc   = {8'h00, next_addr[7:0]};
                                    next_step  = swo_pkg::SWO_P_DATA;
                                    next_state = swo_pkg::SWO_WAITD;
                                end else begin
                                    next_state = swo_pkg::SWO_END;
                                end
                            end
                        endcase
                    end
                end
            end
            swo_pkg::SWO_WAITD: begin
                // Line stays idle high while the stream is empty
                next_tmr = '0;
                if (f_valid) begin
                    pop        = 1'b1;
                    next_hv    = 1'b1;
                    next_dbyte = f_data[7:0];
                    next_last  = f_data[8];
                    next_shreg = f_data[7:0];
                    next_state = swo_pkg::SWO_SLOT;
                end
            end
            swo_pkg::SWO_PROG: begin
                if (tmr == L_PROG) begin
                    next_tmr   = '0;
                    next_state = swo_pkg::SWO_PREC;
                end
            end
            swo_pkg::SWO_PREC: begin
                // Let the line settle back to pull-up before slotting
                if (tmr == L_PREC) begin
                    next_tmr   = '0;
                    next_bitn  = '0;
                    next_step  = swo_pkg::SWO_P_VERIFY;
                    next_state = swo_pkg::SWO_SLOT;
                end
            end
            swo_pkg::SWO_END: begin
                next_done  = 1'b1;
                next_state = swo_pkg::SWO_IDLE;
            end
        endcase
        // Abort is held off during the pulse and its recovery
        if (abort_i && !quit && state != swo_pkg::SWO_IDLE
            && state != swo_pkg::SWO_END && state != swo_pkg::SWO_PROG
            && state != swo_pkg::SWO_PREC) begin
            next_err   = swo_pkg::ERR_ABORT;
            next_quit  = 1'b1;
            next_tmr   = '0;
            next_state = swo_pkg::SWO_RESET;
        end
        next_prog = (next_state == swo_pkg::SWO_PROG);
        rxmode   = (next_step == swo_pkg::SWO_P_CRC)
                || (next_step == swo_pkg::SWO_P_VERIFY);
        next_drv = (next_state == swo_pkg::SWO_RESET)
                || (next_state == swo_pkg::SWO_SLOT
                    && (next_tmr < L_STROBE
                        || (!rxmode && !next_shreg[0]
                            && next_tmr < L_LOW0)));
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= swo_pkg::SWO_IDLE;
            step  <= swo_pkg::SWO_P_ROM;
            tmr   <= '0;
            bitn  <= '0;
            shreg <= '0;
            rx    <= '0;
            crc   <= swo_pkg::CRC16_INIT;
            addr  <= '0;
            dbyte <= '0;
            last  <= 1'b0;
            hv    <= 1'b0;
            mode  <= 1'b0;
            quit  <= 1'b0;
            samp  <= 1'b1;
            retry <= '0;
            err   <= swo_pkg::ERR_NONE;
            done  <= 1'b0;
            drv   <= 1'b0;
            prog  <= 1'b0;
            vbyte <= '0;
            crcin <= '0;
        end else if (ce_i) begin
            state <= next_state;
            step  <= next_step;
            tmr   <= next_tmr;
            bitn  <= next_bitn;
            shreg <= next_shreg;
            rx    <= next_rx;
            crc   <= next_crc;
            addr  <= next_addr;
            dbyte <= next_dbyte;
            last  <= next_last;
            hv    <= next_hv;
            mode  <= next_mode;
            quit  <= next_quit;
            samp  <= next_samp;
            retry <= next_retry;
            err   <= next_err;
            done  <= next_done;
            drv   <= next_drv;
            prog  <= next_prog;
            vbyte <= next_vbyte;
            crcin <= next_crcin;
        end
    end

    assign busy_o    = (state != swo_pkg::SWO_IDLE);
    assign done_o    = done;
    assign err_o     = err;
    assign addr_o    = addr;
    assign verify_o  = vbyte;
    assign crc_o     = crcin;
    assign dq_o      = 1'b0;
    assign dq_oe_n_o = ~drv;
    assign prog_en_o = prog;

endmodule : swo_host

// ---- swo_pkg.sv ----
// Shared constants and types for the one-wire OTP programming host
package swo_pkg;

    // Clock rate
    localparam int CLK_MHZ = 125;

    // Line timing, in nanoseconds
    localparam int T_RESET_NS      = 480000;
    localparam int T_PRES_SMP_NS   = 70000;
    localparam int T_PRES_END_NS   = 480000;
    localparam int T_STROBE_NS     = 1000;
    localparam int T_SAMPLE_NS     = 13000;
    localparam int T_SLOT_NS       = 60000;
    localparam int T_RECOVER_NS    = 5000;
    localparam int T_PROG_NS       = 480000;
    localparam int T_PROG_REC_NS   = 10000;

    // Cycle counts: least times round up, sample points round down
    localparam int C_RESET    = (T_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int C_PRES_SMP = (T_PRES_SMP_NS * CLK_MHZ) / 1000;
    localparam int C_PRES_END = (T_PRES_END_NS * CLK_MHZ + 999) / 1000;
    localparam int C_STROBE   = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int C_SAMPLE   = (T_SAMPLE_NS * CLK_MHZ) / 1000;
    localparam int C_SLOT     = (T_SLOT_NS * CLK_MHZ + 999) / 1000;
    localparam int C_RECOVER  = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int C_PROG     = (T_PROG_NS * CLK_MHZ + 999) / 1000;
    localparam int C_PROG_REC = (T_PROG_REC_NS * CLK_MHZ + 999) / 1000;

    // Level-one and level-two command codes
    localparam logic [7:0] CMD_READ_ID    = 8'h33;
    localparam logic [7:0] CMD_MATCH_ID   = 8'h55;
    localparam logic [7:0] CMD_SKIP_ID    = 8'hcc;
    localparam logic [7:0] CMD_READ_MEM   = 8'hf0;
    localparam logic [7:0] CMD_READ_STAT  = 8'haa;
    localparam logic [7:0] CMD_WRITE_MEM  = 8'h0f;
    localparam logic [7:0] CMD_WRITE_STAT = 8'h55;

    // CRC16 x^16+x^15+x^2+1, bit-reversed for LSB-first shifting
    localparam logic [15:0] CRC16_POLY = 16'ha001;
    localparam logic [15:0] CRC16_INIT = 16'h0000;
    localparam logic [15:0] CRC16_XOR  = 16'h0000;

    // Error codes
    localparam logic [2:0] ERR_NONE     = 3'h0;
    localparam logic [2:0] ERR_PRESENCE = 3'h1;
    localparam logic [2:0] ERR_CRC      = 3'h2;
    localparam logic [2:0] ERR_VERIFY   = 3'h3;
    localparam logic [2:0] ERR_ABORT    = 3'h4;

    // Field layout
    localparam int BYTE_W = 8;
    localparam int CRC_W  = 16;
    localparam int ADDR_W = 16;

    typedef enum logic [2:0] {
        SWO_IDLE, SWO_RESET, SWO_PRES, SWO_SLOT,
        SWO_WAITD, SWO_PROG, SWO_PREC, SWO_END
    } swo_state_e;

    typedef enum logic [2:0] {
        SWO_P_ROM, SWO_P_CMD, SWO_P_ALO, SWO_P_AHI,
        SWO_P_DATA, SWO_P_CRC, SWO_P_VERIFY
    } swo_step_e;

endpackage : swo_pkg

// ---- swo_fifo.sv ----
// Small flip-flop FIFO between the user and the line engine
module swo_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    // Fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Drain side
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
            $error("swo_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    // Ready drops while frozen so the source never loses a word
    assign in_ready_o  = (count != (PW + 1)'(DEPTH)) && ce_i;
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i && ce_i;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (ce_i) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

endmodule : swo_fifo

// ---- swo_host_assertions.sv ----
// Checker for the one-wire OTP host line and status ports
module swo_host_assertions #(
    parameter int RESET_CYC = 60000,
    parameter int SLOT_CYC  = 7500,
    parameter int PROG_CYC  = 60000
) (
    // Watched ports
    input wire logic       clk_i,
    input wire logic       reset_i,
    input wire logic       ce_i,
    input wire logic       start_i,
    input wire logic       busy_o,
    input wire logic       done_o,
    input wire logic [2:0] err_o,
    input wire logic       dq_o,
    input wire logic       dq_oe_n_o,
    input wire logic       prog_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [16:0] low_cnt;
    logic [16:0] prog_cnt;
    // Run lengths of line pull and program pulse
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            low_cnt  <= 17'h0;
            prog_cnt <= 17'h0;
        end else begin
            low_cnt  <= dq_oe_n_o ? 17'h0 : low_cnt + 17'h1;
            prog_cnt <= prog_en_o ? prog_cnt + 17'h1 : 17'h0;
        end
    end
    a_low_width: assert property ($rose(dq_oe_n_o) |->
        low_cnt == swo_pkg::C_STROBE || low_cnt == RESET_CYC ||
        low_cnt == SLOT_CYC - swo_pkg::C_RECOVER) else $error("bad low width");
    a_prog_len: assert property ($fell(prog_en_o) |-> prog_cnt == PROG_CYC)
        else $error("program pulse length wrong");
    a_prog_float: assert property (prog_en_o |-> dq_oe_n_o)
        else $error("line pulled during program pulse");
    a_prog_recover: assert property ($fell(prog_en_o) |-> dq_oe_n_o [*8])
        else $error("no recovery after program pulse");
    a_idle_quiet: assert property (!busy_o |-> dq_oe_n_o && !prog_en_o)
        else $error("line active while idle");
    a_start_reset: assert property (start_i && !busy_o && ce_i |=>
        busy_o && !dq_oe_n_o) else $error("start gave no reset pulse");
    a_done_once: assert property (done_o |=> !done_o && !busy_o)
        else $error("done not a single pulse");
    a_drive_low: assert property (!dq_oe_n_o |-> dq_o == 1'b0)
        else $error("line driven high");
    a_err_hold: assert property (!busy_o && !start_i |=> $stable(err_o))
        else $error("error code lost in idle");
    c_prog: cover property ($rose(prog_en_o));
    c_abort: cover property (done_o && err_o == 3'h4);
    c_absent: cover property (done_o && err_o == 3'h1);
endmodule : swo_host_assertions

bind swo_host swo_host_assertions #(.RESET_CYC(RESET_CYC), .SLOT_CYC(SLOT_CYC),
    .PROG_CYC(PROG_CYC)) u_chk (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .start_i(start_i), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
    .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .prog_en_o(prog_en_o));

// ---- swo_dev_model.sv ----
// Behavioural one-wire OTP device facing the host's line
module swo_dev_model #(
    parameter int RST_NS = 16000
) (
    // Line and programming switch
    input  wire logic dq_i,
    input  wire logic prog_en_o,
    input  wire logic present,
    output logic      pull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [256];
    logic [7:0]  stat [8];
    logic [7:0]  cmd, dat, b;
    logic [15:0] adr, crc;
    time         tf;
    event        rst_ev;
    function automatic logic [15:0] crc_b(logic [15:0] c, logic [7:0] d);
        for (int i = 0; i < 8; i++)
            c = {1'b0, c[15:1]} ^ ((c[0] ^ d[i]) ? 16'ha001 : 16'h0);
        return c;
    endfunction : crc_b
    task automatic rx(output logic [7:0] v);
        for (int i = 0; i < 8; i++) begin
            @(negedge dq_i);
            #8000 v[i] = dq_i;
        end
    endtask : rx
    // Pull held past the host's sample point
    task automatic tx(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge dq_i);
            pull = !v[i];
            #14000 pull = 0;
        end
    endtask : tx
    task run();
        #60000 pull = present;
        #11500 pull = 0;
        rx(b);
        if (b !== 8'hcc) wait (1'b0);
        rx(cmd);
        rx(adr[7:0]);
        rx(adr[15:8]);
        crc = crc_b(crc_b(crc_b(16'h0, cmd), adr[7:0]), adr[15:8]);
        forever begin
            rx(dat);
            crc = crc_b(crc, dat);
            tx(crc, 16);
            @(negedge prog_en_o);
            if (cmd === 8'h0f) mem[adr[7:0]] &= dat;
            else stat[adr[2:0]] &= dat;
            tx({8'h00, cmd === 8'h0f ? mem[adr[7:0]] : stat[adr[2:0]]}, 8);
            if (cmd !== 8'h55) wait (1'b0);
            adr = adr + 16'h1;
            crc = {8'h00, adr[7:0]};
        end
    endtask : run
    always @(negedge dq_i) tf = $time;
    always @(posedge dq_i) if ($time - tf > RST_NS) -> rst_ev;
    initial begin
        pull = 0;
        foreach (mem[i]) mem[i] = 8'hff;
        foreach (stat[i]) stat[i] = 8'hff;
        @(rst_ev);
        forever begin
            pull = 0;
            fork : life
                @(rst_ev);
                run();
            join_any
            disable life;
        end
    end
endmodule : swo_dev_model

// ---- swo_host_tb.sv ----
// Self-checking bench for the one-wire OTP host
module swo_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic m; logic [15:0] a; logic [7:0] d0, d1;} swo_row_s;
    swo_row_s rows [2] = '{'{1'b0, 16'h0012, 8'ha5, 8'h00},
                          '{1'b1, 16'h0100, 8'hf0, 8'h3c}};
    logic clk_i = 0, reset_i = 1, ce_i = 1, start_i = 0, mode_i = 0;
    logic abort_i = 0, wr_valid_i = 0, wr_last_i = 0, present = 1;
    logic [15:0] addr_i = 16'h0, addr_o, crc_o;
    logic [7:0] wr_data_i = 8'h00, verify_o;
    logic wr_ready_o, busy_o, done_o, dq_o, dq_oe_n_o, prog_en_o, pull;
    logic [2:0] err_o;
    wire dq_i = (!dq_oe_n_o || pull) ? 1'b0 : 1'b1;
    int failures = 0, n_tests = 0;
    always #4 clk_i = ~clk_i;
    // Short counts keep each transfer near 0.2 million cycles
    swo_host #(.RESET_CYC(2500), .PRES_END_CYC(9000), .SLOT_CYC(2300),
        .PROG_CYC(20)) dut (.*);
    swo_dev_model dev (.*);
    function automatic logic [15:0] crc8b(logic [15:0] c, logic [7:0] d);
        for (int i = 0; i < 8; i++)
            c = {1'b0, c[15:1]} ^ ((c[0] ^ d[i]) ? 16'ha001 : 16'h0);
        return c;
    endfunction : crc8b
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic push(logic [7:0] d, logic l);
        @(negedge clk_i);
        {wr_valid_i, wr_data_i, wr_last_i} = {1'b1, d, l};
        @(negedge clk_i);
        wr_valid_i = 0;
    endtask : push
    task automatic run(logic m, logic [15:0] a);
        @(negedge clk_i);
        {start_i, mode_i, addr_i} = {1'b1, m, a};
        @(negedge clk_i);
        start_i = 0;
        for (int k = 0; k < 400000 && done_o !== 1'b1; k++) @(negedge clk_i);
        if (done_o !== 1'b1) failures++;
    endtask : run
    task automatic give_verdict();
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        logic [15:0] e;
        repeat (5) @(negedge clk_i);
        reset_i = 0;
        chk("oe_n", 16'h1, {15'h0, dq_oe_n_o});
        foreach (rows[i]) begin
            push(rows[i].d0, !rows[i].m);
            if (rows[i].m) push(rows[i].d1, 1'b1);
            run(rows[i].m, rows[i].a);
            e = crc8b(crc8b(crc8b(crc8b(16'h0, 8'h0f), rows[i].a[7:0]),
                rows[i].a[15:8]), rows[i].d0);
            if (rows[i].m) e = crc8b({8'h00, rows[i].a[7:0] + 8'h01}, rows[i].d1);
            chk("err", 16'h0, {13'h0, err_o});
            chk("crc", e, crc_o);
            chk("verify", {8'h00, rows[i].m ? rows[i].d1 : rows[i].d0},
                {8'h00, verify_o});
            chk("addr", rows[i].a + {15'h0, rows[i].m}, addr_o);
        end
        chk("mem", 16'h00a5, {8'h00, dev.mem[8'h12]});
        chk("stat1", 16'h003c, {8'h00, dev.stat[1]});
        push(8'h11, 1'b1);
        fork
            run(1'b0, 16'h0020);
            begin
                repeat (3500) @(negedge clk_i);
                abort_i = 1;
            end
        join
        abort_i = 0;
        chk("abort", 16'h4, {13'h0, err_o});
        present = 0;
        run(1'b0, 16'h0030);
        chk("absent", 16'h1, {13'h0, err_o});
        for (int k = 0; k < 5 && wr_ready_o === 1'b1; k++) push(8'h00, 1'b0);
        chk("full", 16'h0, {15'h0, wr_ready_o});
        give_verdict();
    end
    initial begin
        #6000000;
        failures++;
        give_verdict();
    end
endmodule : swo_host_tb
